// ===== design/spi_byte_shifter_pkg.sv
// constants and types for the byte-wide serial shifter
`default_nettype none
package spi_byte_shifter_pkg;
    localparam int BYTE_W     = 8;
    localparam int RATE_W     = 3;
    localparam int DELAY_W    = 2;
    localparam int CNT_W      = 12;
    localparam int EDGE_W     = 4;
    // fastest shift clock and system clock, in MHz
    localparam int SCK_MAX_MHZ = 8;
    localparam int CLK_MHZ     = 250;
    // least half period in clk cycles, rounded up
    localparam int HALF_BASE  =
        (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
    // serial output delay step per unit of the delay field, in clk cycles
    localparam int DELAY_STEP = 2;
    localparam logic [EDGE_W-1:0] LAST_EDGE = 4'hF;
    localparam logic [2:0]        LAST_BIT  = 3'h7;
    localparam logic [2:0]        FIRST_BIT = 3'h0;
    typedef enum logic {M_IDLE, M_RUN} mstate_e;
endpackage
`default_nettype wire

// ===== design/spi_byte_shifter.sv
// byte-wide serial shifter: master or slave, optional slave select
`default_nettype none
module spi_byte_shifter (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    input  wire logic       sck_in,
    input  wire logic       ss_n,
    input  wire logic       serial_in,
    input  wire logic       master_mode,
    input  wire logic       ss_enable,
    input  wire logic [2:0] rate_select,
    input  wire logic       bit_order_select,
    input  wire logic       output_delay_hi,
    input  wire logic       output_delay_lo,
    input  wire logic       post_output_level_ctrl,
    input  wire logic       transfer_irq_enable,
    input  wire logic       tx_wr,
    input  wire logic [7:0] tx_data,
    input  wire logic       start_wr,
    input  wire logic       edge_sel_wr,
    input  wire logic       edge_sel_wdata,
    input  wire logic       rx_rd,
    input  wire logic       irq_clr,
    output logic            shift_start_flag,
    output logic            receive_full_flag,
    output logic            transfer_irq_flag,
    output logic            irq,
    output logic            clock_edge_select,
    output logic [7:0]      receive_buffer,
    output logic            sck_out,
    output logic            sck_oe,
    output logic            serial_out_line,
    output logic            serial_out_line_oe
);
    localparam int BW = spi_byte_shifter_pkg::BYTE_W;
    localparam int CW = spi_byte_shifter_pkg::CNT_W;

    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < BW; i++) begin
            r[i] = d[BW-1-i];
        end
        return r;
    endfunction

    logic [BW-1:0]  transmit_buffer, tx_shift, rx_word, shift_register;
    logic [BW-1:0]  m_rx, s_sr, s_rx;
    logic [2:0]     in_s, ss_s, tg_s, s_cnt;
    logic [CW-1:0]  hcnt, dly_cnt, half_len, dly_len;
    logic           start_ok, done, in_f, ss_f, tg_seen, s_done;
    logic           m_bit, m_done, m_out, dly_pend, half_end, lead;
    logic           s_tgl, s_sel;
    spi_byte_shifter_pkg::mstate_e mstate;
    logic [spi_byte_shifter_pkg::EDGE_W-1:0] edge_n;

    assign start_ok = clk_en && start_wr && !shift_start_flag;
    // master divider: the rate field scales the base half period
    assign half_len = CW'(spi_byte_shifter_pkg::HALF_BASE) << rate_select;
    assign dly_len  = CW'(spi_byte_shifter_pkg::DELAY_STEP)
                      * CW'({output_delay_hi, output_delay_lo});
    assign half_end = (mstate == spi_byte_shifter_pkg::M_RUN) && hcnt == '0;
    assign lead     = half_end && !edge_n[0];
    assign rx_word  = master_mode ? m_rx : s_rx;
    assign done     = m_done || (s_done && !master_mode);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once the 2nd and 3rd flops agree

    always_ff @(posedge clk) begin
        if (srst) begin
            in_s <= '0;
            ss_s <= '1;
            tg_s <= '0;
        end else if (clk_en) begin
            in_s <= {in_s[1:0], serial_in};
            ss_s <= {ss_s[1:0], ss_n};
            tg_s <= {tg_s[1:0], s_tgl};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_f    <= 1'b0;
            ss_f    <= 1'b1;
            tg_seen <= 1'b0;
            s_done  <= 1'b0;
        end else if (clk_en) begin
            if (in_s[1] == in_s[2]) in_f <= in_s[2];
            if (ss_s[1] == ss_s[2]) ss_f <= ss_s[2];
            s_done <= 1'b0;
            if (tg_s[1] == tg_s[2] && tg_s[2] != tg_seen) begin
                tg_seen <= tg_s[2];
                s_done  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software side: buffers, flags, edge select

    always_ff @(posedge clk) begin
        if (srst) begin
            transmit_buffer <= '0;
            tx_shift        <= '0;
        end else if (clk_en) begin
            if (tx_wr && !shift_start_flag) transmit_buffer <= tx_data;
            // order is applied once, so both ends send the top bit first
            if (start_ok) tx_shift <= bit_order_select ?
                rev8(transmit_buffer) : transmit_buffer;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shift_start_flag <= 1'b0;
        end else if (clk_en) begin
            if (start_ok) shift_start_flag <= 1'b1;
            else if (done) shift_start_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            receive_buffer <= '0;
        end else if (clk_en && done) begin
            // overwritten on every completion: software must keep up
            receive_buffer <= bit_order_select ? rev8(rx_word) : rx_word;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            receive_full_flag <= 1'b0;
            transfer_irq_flag <= 1'b0;
        end else if (clk_en) begin
            // a completion in the clearing cycle wins over the clear
            if (done) receive_full_flag <= 1'b1;
            else if (rx_rd) receive_full_flag <= 1'b0;
            if (done) transfer_irq_flag <= 1'b1;
            else if (irq_clr) transfer_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= transfer_irq_flag && transfer_irq_enable;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clock_edge_select <= 1'b0;
        end else if (clk_en) begin
            if (done) clock_edge_select <= 1'b0;
            else if (edge_sel_wr && !shift_start_flag)
                clock_edge_select <= edge_sel_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master: internal clock, 16 half periods per byte

    always_ff @(posedge clk) begin
        if (srst) begin
            mstate         <= spi_byte_shifter_pkg::M_IDLE;
            hcnt           <= '0;
            edge_n         <= '0;
            sck_out        <= 1'b0;
            shift_register <= '0;
            m_bit          <= 1'b0;
            m_done         <= 1'b0;
            m_rx           <= '0;
        end else if (clk_en) begin
            m_done <= 1'b0;
            case (mstate)
                spi_byte_shifter_pkg::M_IDLE: begin
                    sck_out <= clock_edge_select;
                    if (start_ok && master_mode) begin
                        mstate         <= spi_byte_shifter_pkg::M_RUN;
                        hcnt           <= half_len - 1'b1;
                        edge_n         <= '0;
                        shift_register <= bit_order_select ?
                            rev8(transmit_buffer) : transmit_buffer;
                    end
                end
                spi_byte_shifter_pkg::M_RUN: begin
                    if (half_end) begin
                        hcnt    <= half_len - 1'b1;
                        edge_n  <= edge_n + 1'b1;
                        sck_out <= ~sck_out;
                        if (lead) begin
                            m_bit <= in_f;
                        end else begin
                            shift_register <= {shift_register[BW-2:0], m_bit};
                        end
                        if (edge_n == spi_byte_shifter_pkg::LAST_EDGE) begin
                            mstate <= spi_byte_shifter_pkg::M_IDLE;
                            m_rx   <= {shift_register[BW-2:0], m_bit};
                            m_done <= 1'b1;
                        end
                    end else begin
                        hcnt <= hcnt - 1'b1;
                    end
                end
                default: mstate <= spi_byte_shifter_pkg::M_IDLE;
            endcase
        end
    end

    // new output bit appears a programmable delay after the shift edge
    always_ff @(posedge clk) begin
        if (srst) begin
            m_out    <= 1'b0;
            dly_pend <= 1'b0;
            dly_cnt  <= '0;
        end else if (clk_en) begin
            if (start_ok && master_mode) begin
                m_out <= bit_order_select ? transmit_buffer[0]
                                          : transmit_buffer[BW-1];
                dly_pend <= 1'b0;
            end else if (m_done) begin
                m_out    <= post_output_level_ctrl;
                dly_pend <= 1'b0;
            end else if (half_end && !lead &&
                         edge_n != spi_byte_shifter_pkg::LAST_EDGE) begin
                dly_pend <= 1'b1;
                dly_cnt  <= dly_len;
            end else if (dly_pend) begin
                if (dly_cnt == '0) begin
                    m_out    <= shift_register[BW-1];
                    dly_pend <= 1'b0;
                end else begin
                    dly_cnt <= dly_cnt - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sck_oe             <= 1'b0;
            serial_out_line_oe <= 1'b0;
        end else if (clk_en) begin
            sck_oe <= master_mode;
            // slave select framing applies only to a slave
            serial_out_line_oe <= master_mode || !ss_enable || !ss_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slave: runs on the master's clock; fixed edge, rate set by master

    assign s_sel = !(ss_enable && ss_n);

    // tx_shift is frozen while busy, so the link side reads a quiet word
    always_ff @(posedge sck_in or posedge srst) begin
        if (srst) begin
            s_cnt <= spi_byte_shifter_pkg::FIRST_BIT;
            s_sr  <= '0;
            s_rx  <= '0;
            s_tgl <= 1'b0;
        end else if (s_sel) begin
            s_cnt <= s_cnt + 1'b1;
            if (s_cnt == spi_byte_shifter_pkg::FIRST_BIT)
                s_sr <= {tx_shift[BW-2:0], serial_in};
            else
                s_sr <= {s_sr[BW-2:0], serial_in};
            if (s_cnt == spi_byte_shifter_pkg::LAST_BIT) begin
                s_rx  <= {s_sr[BW-2:0], serial_in};
                s_tgl <= ~s_tgl;
            end
        end
    end

    always_comb begin
        if (master_mode)
            serial_out_line = m_out;
        else if (s_cnt == spi_byte_shifter_pkg::FIRST_BIT)
            serial_out_line = tx_shift[BW-1];
        else
            serial_out_line = s_sr[BW-1];
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_full_set;
        clk_en && done |=> receive_full_flag;
    endproperty
    a_full_set: assert property (p_full_set) else $error("full not set");
    property p_busy;
        start_ok ##1 !done[*2] |-> shift_start_flag;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped");
    property p_rxbuf;
        clk_en && done && !bit_order_select
            |=> receive_buffer == $past(rx_word);
    endproperty
    a_rxbuf: assert property (p_rxbuf) else $error("rx byte lost");
    property p_full_clr;
        clk_en && rx_rd && !done |=> !receive_full_flag;
    endproperty
    a_full_clr: assert property (p_full_clr) else $error("full stuck");
    property p_tx_ign;
        clk_en && tx_wr && shift_start_flag
            |=> $stable(transmit_buffer);
    endproperty
    a_tx_ign: assert property (p_tx_ign) else $error("tx write taken");
    property p_edge_clr;
        clk_en && done |=> !clock_edge_select;
    endproperty
    a_edge_clr: assert property (p_edge_clr) else $error("edge kept");
    property p_irq;
        irq |-> $past(transfer_irq_flag) && $past(transfer_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq unmasked");
    property p_eight;
        clk_en && half_end && edge_n == spi_byte_shifter_pkg::LAST_EDGE
            |=> mstate == spi_byte_shifter_pkg::M_IDLE && m_done;
    endproperty
    a_eight: assert property (p_eight) else $error("edge count");
    property p_release;
        clk_en ##1 clk_en && !master_mode && ss_enable && ss_f
            |=> !serial_out_line_oe;
    endproperty
    a_release: assert property (p_release) else $error("out driven");
endmodule
`default_nettype wire

// ===== verification/spi_peer_model.sv
// far-side serial peer: slave for master runs, master for slave runs
`default_nettype none
module spi_peer_model (
    input  wire logic sck_from_dut,
    input  wire logic dut_out,
    output logic      sck_to_dut,
    output logic      sel_n,
    output logic      data_to_dut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] send;
    logic [7:0] got;
    logic       idle_lvl;
    int         n;
    initial begin
        sck_to_dut = 1'h0;
        sel_n = 1'h1;
        data_to_dut = 1'h0;
        idle_lvl = 1'h0;
        n = 8;
    end
    ////////////////////////////////////////////////////////////////////////
    // slave role: first bit must sit on the line before the first edge
    task automatic arm(input logic [7:0] b, input logic pol);
        send = b;
        idle_lvl = pol;
        n = 0;
        data_to_dut = b[7];
    endtask
    always @(sck_from_dut) begin
        if (n < 8 && sck_from_dut !== idle_lvl) begin
            got[7-n] = dut_out;
        end else if (n < 8) begin
            n = n + 1;
            // a released line shows the inverse, never a held value
            data_to_dut = (n < 8) ? send[7-n] : ~data_to_dut;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // master role: frame clocks only inside the select window
    task automatic frame(input logic [7:0] b);
        sel_n = 1'h0;
        data_to_dut = b[7];
        for (int i = 0; i < 8; i++) begin
            #62.5 got[7-i] = dut_out;
            sck_to_dut = 1'h1;
            #62.5 sck_to_dut = 1'h0;
            data_to_dut = (i < 7) ? b[6-i] : ~data_to_dut;
        end
        #62.5 sel_n = 1'h1;
    endtask
    // clocks with the select high, which the slave must not act on
    task automatic stray();
        repeat (8) begin
            #62.5 sck_to_dut = 1'h1;
            #62.5 sck_to_dut = 1'h0;
        end
    endtask
endmodule
`default_nettype wire

// ===== verification/spi_byte_shifter_bench.sv
// self-checking bench for the byte-wide serial shifter
`default_nettype none
module spi_byte_shifter_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, srst, clk_en, sck_in, ss_n, serial_in, master_mode;
    logic       ss_enable, bit_order_select, output_delay_hi;
    logic       output_delay_lo, post_output_level_ctrl;
    logic       transfer_irq_enable, tx_wr, start_wr, edge_sel_wr;
    logic       edge_sel_wdata, rx_rd, irq_clr, shift_start_flag;
    logic       receive_full_flag, transfer_irq_flag, irq;
    logic       clock_edge_select, sck_out, sck_oe, serial_out_line;
    logic       serial_out_line_oe;
    logic [2:0] rate_select;
    logic [7:0] tx_data, receive_buffer;
    int         error_cnt, tests_run, cyc, rises, t1, t2;

    spi_byte_shifter dut (
        .clk(clk), .srst(srst), .clk_en(clk_en), .sck_in(sck_in),
        .ss_n(ss_n), .serial_in(serial_in), .master_mode(master_mode),
        .ss_enable(ss_enable), .rate_select(rate_select),
        .bit_order_select(bit_order_select),
        .output_delay_hi(output_delay_hi),
        .output_delay_lo(output_delay_lo),
        .post_output_level_ctrl(post_output_level_ctrl),
        .transfer_irq_enable(transfer_irq_enable), .tx_wr(tx_wr),
        .tx_data(tx_data), .start_wr(start_wr),
        .edge_sel_wr(edge_sel_wr), .edge_sel_wdata(edge_sel_wdata),
        .rx_rd(rx_rd), .irq_clr(irq_clr),
        .shift_start_flag(shift_start_flag),
        .receive_full_flag(receive_full_flag),
        .transfer_irq_flag(transfer_irq_flag), .irq(irq),
        .clock_edge_select(clock_edge_select),
        .receive_buffer(receive_buffer), .sck_out(sck_out),
        .sck_oe(sck_oe), .serial_out_line(serial_out_line),
        .serial_out_line_oe(serial_out_line_oe)
    );
    spi_peer_model p (
        // an undriven data line reads as the inverse of its last value
        .sck_from_dut(sck_out),
        .dut_out(serial_out_line_oe ? serial_out_line : ~serial_out_line),
        .sck_to_dut(sck_in), .sel_n(ss_n), .data_to_dut(serial_in)
    );

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge sck_out) begin
        if (rises == 0) t1 = cyc;
        if (rises == 1) t2 = cyc;
        rises++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk) #1 s = 1'h1;
        @(posedge clk) #1 s = 1'h0;
    endtask
    // bounded wait; a miss shows up in the checks that follow
    task automatic wait_full(input int lim);
        for (int k = 0; k < lim && receive_full_flag !== 1'h1; k++) begin
            @(posedge clk) #1;
        end
        @(posedge clk) #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_master(input logic [7:0] b, input logic [7:0] pb,
                            input logic pol, input logic [2:0] rs,
                            input logic load);
        logic [7:0] eb;
        logic [7:0] ep;
        // lsb-first order mirrors both bytes between the line and the software side
        for (int i = 0; i < 8; i++) begin
            eb[i] = bit_order_select ? b[7-i] : b[i];
            ep[i] = bit_order_select ? pb[7-i] : pb[i];
        end
        master_mode = 1'h1;
        ss_enable = 1'h0;
        rate_select = rs;
        edge_sel_wdata = pol;
        pulse(edge_sel_wr);
        tx_data = b;
        if (load) pulse(tx_wr);
        // let the idle level settle so the peer does not count it
        repeat (2) @(posedge clk) #1;
        p.arm(pb, pol);
        rises = 0;
        pulse(start_wr);
        @(posedge clk) #1;
        chk("busy", 8'h01, {7'h00, shift_start_flag});
        tx_data = ~b;
        pulse(tx_wr);
        wait_full(320 << rs);
        chk("rx byte", ep, receive_buffer);
        chk("tx byte", eb, p.got);
        chk("flags", 8'h1B, {3'h0, serial_out_line_oe, sck_oe,
            shift_start_flag, receive_full_flag,
            transfer_irq_flag});
        chk("rest", {7'h00, post_output_level_ctrl},
            {7'h00, serial_out_line});
        chk("edge sel", 8'h00, {7'h00, clock_edge_select});
        chk("clocks", 8'h08, 8'(rises));
        chk("period", 8'(32 << rs), 8'(t2 - t1));
        transfer_irq_enable = 1'h1;
        repeat (2) @(posedge clk) #1;
        chk("irq on", 8'h01, {7'h00, irq});
        pulse(rx_rd);
        pulse(irq_clr);
        repeat (2) @(posedge clk) #1;
        chk("cleared", 8'h00, {6'h00, receive_full_flag,
            transfer_irq_flag});
        chk("irq off", 8'h00, {7'h00, irq});
        transfer_irq_enable = 1'h0;
        $display("test master %h done", b);
    endtask
    task automatic t_slave(input logic [7:0] b, input logic [7:0] pb);
        master_mode = 1'h0;
        ss_enable = 1'h1;
        rate_select = 3'h7;
        edge_sel_wdata = 1'h1;
        pulse(edge_sel_wr);
        tx_data = b;
        pulse(tx_wr);
        pulse(start_wr);
        repeat (2) @(posedge clk) #1;
        chk("unsel oe", 8'h00, {6'h00, sck_oe,
            serial_out_line_oe});
        p.stray();
        repeat (8) @(posedge clk) #1;
        chk("unsel", 8'h00, {7'h00, receive_full_flag});
        p.frame(pb);
        wait_full(40);
        chk("slave rx", pb, receive_buffer);
        chk("slave tx", b, p.got);
        chk("slave done", 8'h01, {7'h00, receive_full_flag});
        chk("slave edge", 8'h00, {7'h00, clock_edge_select});
        $display("test slave %h done", b);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, srst, clk_en, master_mode, ss_enable, bit_order_select} = '0;
        {output_delay_hi, output_delay_lo, post_output_level_ctrl} = '0;
        {transfer_irq_enable, tx_wr, start_wr, edge_sel_wr} = '0;
        {edge_sel_wdata, rx_rd, irq_clr} = '0;
        // raise reset after time zero so the link-side reset sees an edge
        #1;
        {srst, clk_en, rate_select, tx_data} = 13'h1800;
        {error_cnt, tests_run, cyc, rises, t1, t2} = '0;
        repeat (5) @(posedge clk);
        #1 srst = 1'h0;
        chk("reset", 8'h00, {shift_start_flag, receive_full_flag,
            transfer_irq_flag, irq, clock_edge_select, sck_out, sck_oe,
            serial_out_line_oe});
        chk("reset rx", 8'h00, receive_buffer);
        t_master(8'hA5, 8'h3C, 1'h0, 3'h0, 1'h1);
        t_master(8'h81, 8'h7E, 1'h1, 3'h1, 1'h1);
        // resend without a write: the write during the shift was dropped
        t_master(8'h81, 8'hC3, 1'h0, 3'h0, 1'h0);
        {output_delay_hi, output_delay_lo, post_output_level_ctrl} = '1;
        t_master(8'h5A, 8'h96, 1'h0, 3'h2, 1'h1);
        bit_order_select = 1'h1;
        t_master(8'hC5, 8'h1E, 1'h0, 3'h0, 1'h1);
        bit_order_select = 1'h0;
        t_slave(8'hE1, 8'h2D);
        print_verdict();
    end
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
